// ===== rtl/lte_cfg.svh
`ifndef LTE_CFG_SVH
`define LTE_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define LTE_OFF_CTRL      32'h0000_0000
`define LTE_OFF_STATUS    32'h0000_0004

// ****************************************
// Control field positions
// ****************************************
`define LTE_CTRL_ALLONES  0
`define LTE_CTRL_SINGLE   1
`define LTE_CTRL_RATE_LO  2
`define LTE_CTRL_RATE_HI  3
`define LTE_CTRL_FALLING  4
`define LTE_CTRL_BODIS    5
`define LTE_CTRL_LOOP_LO  6
`define LTE_CTRL_LOOP_HI  7
`define LTE_CTRL_WIDTH    8

// ****************************************
// Reset values
// ****************************************
`define LTE_CTRL_RESET    8'h02

// ****************************************
// Bus answers
// ****************************************
`define LTE_RESP_OKAY     2'h0
`define LTE_RESP_SLVERR   2'h2

`endif

// ===== rtl/lte_pkg.sv
package lte_pkg;

  // Line rate selection
  typedef enum logic [1:0] {
    LTE_RATE_E3  = 2'h0,
    LTE_RATE_DS3 = 2'h1,
    LTE_RATE_STS = 2'h2
  } lte_rate_t;

  // Loopback selection
  typedef enum logic [1:0] {
    LTE_LOOP_NONE   = 2'h0,
    LTE_LOOP_ANALOG = 2'h1,
    LTE_LOOP_REMOTE = 2'h2,
    LTE_LOOP_DIGITAL = 2'h3
  } lte_loop_t;

  // Control settings carried into the link domain
  typedef struct packed {
    lte_loop_t loopMode;
    logic      buildOutDisable;
    logic      sampleFalling;
    lte_rate_t rate;
    logic      singleRail;
    logic      allOnesRequest;
  } lte_ctrl_t;

  // Line symbol pair
  typedef struct packed {
    logic tip;
    logic ring;
  } lte_sym_t;

endpackage : lte_pkg

// ===== rtl/line_transmit_encoder.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lte_cfg.svh"

module line_transmit_encoder
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                txLineClock,
  input  wire logic                txPositiveRail,
  input  wire logic                txNegativeRail,
  output var  lte_pkg::lte_sym_t   lineOut,
  output var  logic                buildOutEnable,
  input  wire logic [3:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [3:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import lte_pkg::*;

  // ****************************************
  // Register bus slave (clock domain)
  // ****************************************
  logic                      awHeld_ff;
  logic                      wHeld_ff;
  logic [3:0]                awAddr_ff;
  logic [31:0]               wData_ff;
  logic [3:0]                wStrb_ff;
  logic                      bValid_ff;
  logic [1:0]                bResp_ff;
  logic                      rValid_ff;
  logic [31:0]               rData_ff;
  logic [1:0]                rResp_ff;
  logic [`LTE_CTRL_WIDTH-1:0] ctrl_ff;
  logic                      doWrite;
  logic                      wrCtrl;
  logic                      rdCtrl;
  logic                      rdStat;
  logic [31:0]               statWord;
  logic [31:0]               rdWord;
  logic [1:0]                rdResp;
  logic [1:0]                wrResp;
  logic                      onesSeen_s1_ff;
  logic                      onesSeen_s2_ff;
  logic                      polSeen_s1_ff;
  logic                      polSeen_s2_ff;

  // Address and data may come in either order; hold each until both are here
  assign s_axi_awready = !awHeld_ff && !bValid_ff;
  assign s_axi_wready  = !wHeld_ff && !bValid_ff;
  assign doWrite       = awHeld_ff && wHeld_ff && !bValid_ff;
  assign wrCtrl        = doWrite && (awAddr_ff == 4'(`LTE_OFF_CTRL));
  // Writes to the read-only status word are accepted and dropped
  assign wrResp        = (wrCtrl || awAddr_ff == 4'(`LTE_OFF_STATUS)) ? `LTE_RESP_OKAY
                                                                     : `LTE_RESP_SLVERR;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;

  // Write channel capture and response
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff  <= `LTE_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff  <= wrResp;
      end
      else if (bValid_ff && s_axi_bready)
        bValid_ff <= 1'b0;
    end
  end

  // Control register; only the low byte lane holds bits
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_ff <= `LTE_CTRL_RESET;
    else if (wrCtrl && wStrb_ff[0])
      ctrl_ff <= wData_ff[`LTE_CTRL_WIDTH-1:0];
  end

  // Read decode
  assign rdCtrl        = (s_axi_araddr == 4'(`LTE_OFF_CTRL));
  assign rdStat        = (s_axi_araddr == 4'(`LTE_OFF_STATUS));
  assign statWord      = {30'h0000_0000, polSeen_s2_ff, onesSeen_s2_ff};
  // Unmapped words read as zero with an error answer
  assign rdWord        = rdCtrl ? {24'h00_0000, ctrl_ff} : (rdStat ? statWord : 32'h0000_0000);
  assign rdResp        = (rdCtrl || rdStat) ? `LTE_RESP_OKAY : `LTE_RESP_SLVERR;
  assign s_axi_arready = !rValid_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;

  // Read answer one cycle after the address is taken
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rValid_ff <= 1'b0;
      rData_ff  <= 32'h0000_0000;
      rResp_ff  <= `LTE_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_ff <= 1'b1;
      rData_ff  <= rdWord;
      rResp_ff  <= rdResp;
    end
    else if (rValid_ff && s_axi_rready)
      rValid_ff <= 1'b0;
  end

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Register word and its link-domain copy must keep the same width
  if (`LTE_CTRL_WIDTH != $bits(lte_ctrl_t))
  begin : g_ctrlWidthCheck
    $error("control width differs from the settings type");
  end

  // ****************************************
  // Crossing into the link domain
  // ****************************************
  // Settings are quasi-static; each bit is synchronised on its own, so a
  // multi-bit change may land over two link clocks, which is harmless here.
  lte_ctrl_t ctrlSync1_ff;
  lte_ctrl_t ctrlSync2_ff;
  logic      linkRst_s1_ff;
  logic      linkRst_s2_ff;

  // Bus reset reaches the link side two link clocks late, so the link
  // clock must run while reset is held
  always_ff @(posedge txLineClock)
  begin
    ctrlSync1_ff  <= ctrl_ff;
    ctrlSync2_ff  <= ctrlSync1_ff;
    linkRst_s1_ff <= rst;
    linkRst_s2_ff <= linkRst_s1_ff;
  end

  // ****************************************
  // Input sampling on either clock edge
  // ****************************************
  logic rise_s1_ff;
  logic rise_s2_ff;
  logic riseN_s1_ff;
  logic riseN_s2_ff;
  logic fall_s1_ff;
  logic fall_s2_ff;
  logic fallN_s1_ff;
  logic fallN_s2_ff;
  logic dataPos;
  logic dataNeg;

  // Rising-edge capture path
  always_ff @(posedge txLineClock)
  begin
    rise_s1_ff  <= txPositiveRail;
    rise_s2_ff  <= rise_s1_ff;
    riseN_s1_ff <= txNegativeRail;
    riseN_s2_ff <= riseN_s1_ff;
  end

  // Falling-edge capture, re-timed to the rising edge
  always_ff @(negedge txLineClock)
  begin
    fall_s1_ff  <= txPositiveRail;
    fallN_s1_ff <= txNegativeRail;
  end

  always_ff @(posedge txLineClock)
  begin
    fall_s2_ff  <= fall_s1_ff;
    fallN_s2_ff <= fallN_s1_ff;
  end

  assign dataPos = ctrlSync2_ff.sampleFalling ? fall_s2_ff : rise_s2_ff;
  assign dataNeg = ctrlSync2_ff.sampleFalling ? fallN_s2_ff : riseN_s2_ff;

  // ****************************************
  // Zero-substitution encoder
  // ****************************************
  // Three-deep delay line; a substituted run rewrites its newest slot, and its oldest for B3ZS B0V.
  logic [2:0] delayMark_ff;
  logic [2:0] delayViol_ff;
  logic [1:0] zeroCount_ff;
  logic       lastPolNeg_ff;
  logic       oddSinceViol_ff;
  logic       isHdb3;
  logic       allOnesActive;
  logic       inBit;
  logic [1:0] runLen;
  logic       runDone;
  logic       useBipolar;
  logic       hdb3Lead;
  logic       onesActive_ff;
  logic [2:0] nxt_delayMark;
  logic [2:0] nxt_delayViol;
  logic       outMark;
  logic       outViol;
  logic       markNeg;
  logic       nxt_lastPolNeg;
  logic       nxt_oddSinceViol;
  logic [1:0] nxt_zeroCount;
  lte_sym_t   nxt_lineOut;

  assign isHdb3 = (ctrlSync2_ff.rate == LTE_RATE_E3);
  // blocked in analog and remote loopback
  assign allOnesActive = ctrlSync2_ff.allOnesRequest &&
                         ctrlSync2_ff.loopMode != LTE_LOOP_ANALOG &&
                         ctrlSync2_ff.loopMode != LTE_LOOP_REMOTE;
  assign inBit   = allOnesActive ? 1'b1 : dataPos;
  assign runLen  = isHdb3 ? 2'd3 : 2'd2;
  assign runDone = !inBit && (zeroCount_ff == runLen);
  assign useBipolar = !oddSinceViol_ff;

  // Substitution rewrites the window: B0V puts B at the oldest zero of three
  // (B3ZS) and B00V puts B at the oldest zero of four (HDB3, one already out).
  always_comb
  begin
    nxt_delayMark = {delayMark_ff[1:0], inBit};
    nxt_delayViol = {delayViol_ff[1:0], 1'b0};
    if (runDone)
    begin
      nxt_delayMark[0] = 1'b1;
      nxt_delayViol[0] = 1'b1;
      // B3ZS B0V: the B lands on the oldest zero still in the window
      if (useBipolar && !isHdb3)
      begin
        nxt_delayMark[2] = 1'b1;
      end
    end
  end

  assign nxt_zeroCount = (inBit || runDone) ? 2'd0 : zeroCount_ff + 2'd1;
  // HDB3 B00V: the oldest zero of four is leaving now, so its B is added
  // on the way out; it is an ordinary mark and keeps the alternation
  assign hdb3Lead      = runDone && useBipolar && isHdb3;
  assign outMark       = delayMark_ff[2] || hdb3Lead;
  assign outViol       = delayViol_ff[2];
  assign markNeg       = outViol ? lastPolNeg_ff : !lastPolNeg_ff;
  assign nxt_lastPolNeg   = outMark ? markNeg : lastPolNeg_ff;
  assign nxt_oddSinceViol = runDone ? 1'b0
                          : (inBit ? !oddSinceViol_ff : oddSinceViol_ff);

  always_comb
  begin
    if (!ctrlSync2_ff.singleRail && !allOnesActive)
    begin
      nxt_lineOut.tip  = dataPos;
      nxt_lineOut.ring = dataNeg;
    end
    else
    begin
      nxt_lineOut.tip  = outMark && !markNeg;
      nxt_lineOut.ring = outMark && markNeg;
    end
  end

  always_ff @(posedge txLineClock)
  begin
    if (linkRst_s2_ff)
    begin
      delayMark_ff    <= 3'h0;
      delayViol_ff    <= 3'h0;
      onesActive_ff   <= 1'b0;
      zeroCount_ff    <= 2'd0;
      lastPolNeg_ff   <= 1'b1;
      oddSinceViol_ff <= 1'b0;
      lineOut         <= '0;
    end
    else
    begin
      delayMark_ff    <= nxt_delayMark;
      delayViol_ff    <= nxt_delayViol;
      onesActive_ff   <= allOnesActive;
      zeroCount_ff    <= nxt_zeroCount;
      lastPolNeg_ff   <= nxt_lastPolNeg;
      oddSinceViol_ff <= nxt_oddSinceViol;
      lineOut         <= nxt_lineOut;
    end
  end

  // ****************************************
  // Build-out and status back to bus domain
  // ****************************************
  // bit low enables build-out, except at the E3 rate
  always_ff @(posedge txLineClock)
  begin
    if (linkRst_s2_ff)
      buildOutEnable <= 1'b0;
    else
      buildOutEnable <= !ctrlSync2_ff.buildOutDisable && !isHdb3;
  end

  // Status levels cross back through two flops; only link flops are sent,
  // since a decode could glitch right at the bus sampling edge
  always_ff @(posedge clock)
  begin
    onesSeen_s1_ff <= onesActive_ff;
    onesSeen_s2_ff <= onesSeen_s1_ff;
    polSeen_s1_ff  <= lastPolNeg_ff;
    polSeen_s2_ff  <= polSeen_s1_ff;
  end

endmodule : line_transmit_encoder
`default_nettype wire

// ===== verif/lte_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "lte_cfg.svh"

module lte_checker
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              txLineClock,
  input wire lte_pkg::lte_sym_t lineOut,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [3:0]        s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  import lte_pkg::*;
  // ****
  // Bus and line checks
  // ****
  // Read taken, and read of a word past the map
  sequence rdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rdHole;
    rdTake ##0 s_axi_araddr[3];
  endsequence

  chk_read_answer: assert property (@(posedge clock) disable iff (rst)
    rdTake |=> s_axi_rvalid) else $error("read answer missing");
  chk_hole_err: assert property (@(posedge clock) disable iff (rst)
    rdHole |=> s_axi_rresp == `LTE_RESP_SLVERR) else $error("hole not refused");
  chk_read_stands: assert property (@(posedge clock) disable iff (rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  chk_read_ends: assert property (@(posedge clock) disable iff (rst)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  chk_write_stands: assert property (@(posedge clock) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  chk_read_block: assert property (@(posedge clock) disable iff (rst)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  chk_write_block: assert property (@(posedge clock) disable iff (rst)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  chk_reset_clear: assert property (@(posedge clock)
    rst |=> !s_axi_bvalid && !s_axi_rvalid) else $error("answer kept in reset");
  chk_mark_single: assert property (
    @(posedge txLineClock) disable iff (rst)
    !(lineOut.tip && lineOut.ring)) else $error("both marks at once");
endmodule : lte_checker

bind line_transmit_encoder lte_checker u_chk
(
  .clock         (clock),
  .rst           (rst),
  .txLineClock   (txLineClock),
  .lineOut       (lineOut),
  .s_axi_awready (s_axi_awready),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready)
);
`default_nettype wire

// ===== verif/lte_framer_model.sv
`timescale 1ns/1ps
`default_nettype none

module lte_framer_model
(
  input  wire logic       sendFalling,
  input  wire logic [7:0] posPattern,
  input  wire logic [7:0] negPattern,
  output var  logic       txLineClock,
  output var  logic       txPositiveRail,
  output var  logic       txNegativeRail
);
  // ****
  // Framer side
  // ****
  int idx = 0;

  // free running clock
  // Bench rate is slower than line rate to keep the run short
  initial
  begin
    txLineClock = 1'b0;
    #13;
    forever #62.5 txLineClock = ~txLineClock;
  end

  // serial rails
  // Launch on the edge opposite the sampling one, half a period of margin
  always @(txLineClock)
  begin
    if (txLineClock == sendFalling)
    begin
      idx = (idx + 1) % 8;
      txPositiveRail <= posPattern[idx];
      txNegativeRail <= negPattern[idx];
    end
  end
endmodule : lte_framer_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lte_cfg.svh"

module tb;
  import lte_pkg::*;
  logic        clock, rst, lineClock, posRail, negRail, sendFalling, buildOn;
  logic [7:0]  posPat, negPat, tips, rings, alts;
  lte_sym_t    lineOut;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          err_total, compares, cyc;

  lte_framer_model u_fr (.sendFalling(sendFalling), .posPattern(posPat),
    .negPattern(negPat), .txLineClock(lineClock), .txPositiveRail(posRail),
    .txNegativeRail(negRail));

  line_transmit_encoder u_dut (.clock(clock), .rst(rst), .txLineClock(lineClock),
    .txPositiveRail(posRail), .txNegativeRail(negRail), .lineOut(lineOut),
    .buildOutEnable(buildOn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ****
  // Bus tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each released once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clock);
    awaddr <= a[3:0];
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge clock);
      da = da | awready;
      dw = dw | wready;
      @(posedge clock);
      if (da) awvalid <= 1'b0;
      if (dw) wvalid <= 1'b0;
    end
    @(negedge clock);
    while (!bvalid) @(negedge clock);
    chk({30'h0, bresp}, {30'h0, `LTE_RESP_OKAY});
    @(posedge clock);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r,
                    input logic [31:0] m);
    @(posedge clock);
    araddr <= a[3:0];
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge clock);
    while (!arready) @(negedge clock);
    @(posedge clock);
    arvalid <= 1'b0;
    @(negedge clock);
    while (!rvalid) @(negedge clock);
    chk(rdata & m, e);
    chk({30'h0, rresp}, {30'h0, r});
    @(posedge clock);
    rready <= 1'b0;
  endtask : rd

  // Set mode, let it cross, then count marks over three 8-bit periods
  task automatic run(input logic [7:0] c, input logic [15:0] pn, input logic sf,
                     input logic [31:0] e);
    logic pt, pr;
    @(posedge clock);
    posPat <= pn[15:8];
    negPat <= pn[7:0];
    sendFalling <= sf;
    wr(`LTE_OFF_CTRL, {24'h00_0000, c});
    repeat (12) @(negedge lineClock);
    tips = 8'h00;
    rings = 8'h00;
    alts = 8'h00;
    pt = 1'b0;
    pr = 1'b0;
    repeat (24)
    begin
      @(negedge lineClock);
      tips = tips + {7'h00, lineOut.tip};
      rings = rings + {7'h00, lineOut.ring};
      alts = alts + {7'h00, (pt && lineOut.tip) || (pr && lineOut.ring)};
      pt = lineOut.tip;
      pr = lineOut.ring;
    end
    chk({7'h00, buildOn, tips, rings, alts}, e);
  endtask : run

  task automatic print_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ****
  // Clock, timeout, sequence
  // ****
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Whole run needs about 900 cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      print_verdict();
    end
  end

  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3f;
    {awvalid, wvalid, bready, arvalid, rready, sendFalling} = 6'h00;
    {awaddr, araddr, wdata, posPat, negPat} = '0;
    {err_total, compares, cyc} = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(`LTE_OFF_CTRL, {24'h00_0000, `LTE_CTRL_RESET}, `LTE_RESP_OKAY, 32'hffff_ffff);
    rd(32'h0000_0008, 32'h0000_0000, `LTE_RESP_SLVERR, 32'hffff_ffff);
    run(8'h07, 16'h5224, 1'b0, 32'h010c_0c00);
    run(8'h41, 16'h0000, 1'b0, 32'h0000_0000);
    rd(`LTE_OFF_STATUS, 32'h0000_0000, `LTE_RESP_OKAY, 32'h0000_0001);
    run(8'h81, 16'h0000, 1'b0, 32'h0000_0000);
    run(8'hc1, 16'h0000, 1'b0, 32'h000c_0c00);
    rd(`LTE_OFF_STATUS, 32'h0000_0001, `LTE_RESP_OKAY, 32'h0000_0001);
    run(8'h02, 16'h0000, 1'b0, 32'h0006_0600);
    run(8'h06, 16'h0000, 1'b0, 32'h0108_0800);
    run(8'h2a, 16'h0000, 1'b0, 32'h0008_0800);
    run(8'h00, 16'h5224, 1'b0, 32'h0009_0600);
    run(8'h14, 16'h5224, 1'b1, 32'h0109_0600);
    rd(`LTE_OFF_CTRL, 32'h0000_0014, `LTE_RESP_OKAY, 32'hffff_ffff);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
